// file: rtl/pldmc_pkg.sv
package pldmc_pkg;
  // ----------------------------------------
  // array shape
  // ----------------------------------------
  localparam int unsigned NUM_CELLS = 8;
  localparam int unsigned PT_PER_CELL = 8;
  localparam int unsigned PT_BITS = NUM_CELLS * PT_PER_CELL;
  localparam int unsigned SIG_BITS = 64;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_PTMASK_LO = 8'h08;
  localparam logic [7:0] OFF_PTMASK_HI = 8'h0C;
  localparam logic [7:0] OFF_SIG_LO = 8'h10;
  localparam logic [7:0] OFF_SIG_HI = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CTRL_PROG_BIT = 0;
  localparam int unsigned CTRL_SECURE_BIT = 1;
  localparam int unsigned CTRL_ERASE_BIT = 2;
  localparam int unsigned CTRL_PRELOAD_BIT = 3;
  localparam int unsigned CTRL_STANDBY_BIT = 4;
  localparam int unsigned CFG_REGS_OK_BIT = 0;
  localparam int unsigned CFG_EMUL_BIT = 1;
  localparam int unsigned CFG_MODE_LSB = 8;
  localparam int unsigned CFG_POL_LSB = 16;

  // ----------------------------------------
  // reset / erased values
  // ----------------------------------------
  localparam logic [7:0] CELL_RESET = 8'h00;
  localparam logic [PT_BITS-1:0] PTMASK_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [SIG_BITS-1:0] SIG_ERASED = 64'h0000_0000_0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STANDBY_NS = 50;
  localparam int unsigned STANDBY_CYCLES = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_W = $clog2(STANDBY_CYCLES + 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(STANDBY_CYCLES - 1);

  // ----------------------------------------
  // macrocell configurations
  // ----------------------------------------
  typedef enum logic [5:0] {
    PLDMC_REG  = 6'b00_0001,
    PLDMC_RIO  = 6'b00_0010,
    PLDMC_COUT = 6'b00_0100,
    PLDMC_CIO  = 6'b00_1000,
    PLDMC_IN   = 6'b01_0000,
    PLDMC_OFF  = 6'b10_0000
  } pldmc_mode_t;

  // decode of the two global bits and one local bit
  function automatic pldmc_mode_t pldmc_decode(input logic regs_ok, input logic emul,
      input logic m);
    pldmc_mode_t r;
    r = PLDMC_OFF;
    case ({regs_ok, emul, m})
      3'b010: r = PLDMC_REG;
      3'b011: r = PLDMC_RIO;
      3'b100: r = PLDMC_COUT;
      3'b101: r = PLDMC_IN;
      3'b111: r = PLDMC_CIO;
      default: r = PLDMC_OFF;
    endcase
    return r;
  endfunction : pldmc_decode
endpackage : pldmc_pkg

// file: rtl/pldmc_top.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
module pldmc_top
  import pldmc_pkg::*;
#(
  parameter bit ZERO_POWER = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PT_BITS-1:0] pterm,
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  input wire logic [NUM_CELLS-1:0] io_in,
  output logic [NUM_CELLS-1:0] io_out,
  output logic [NUM_CELLS-1:0] io_oe,
  output logic [NUM_CELLS-1:0] fb,
  output logic standby
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic regs_ok_q, regs_ok_d, emul_q, emul_d, prog_q, prog_d, secure_q, secure_d;
  logic [NUM_CELLS-1:0] mode_q, mode_d, pol_q, pol_d;
  logic [PT_BITS-1:0] ptmask_q, ptmask_d;
  logic [SIG_BITS-1:0] sig_q, sig_d;
  logic [NUM_CELLS-1:0] q_q, q_d;
  logic [NUM_CELLS-1:0] io_out_q, io_out_d, io_oe_q, io_oe_d, fb_q, fb_d;
  logic standby_q, standby_d;
  logic [IDLE_W-1:0] idle_q, idle_d;
  logic [PT_BITS-1:0] pt_prev_q;
  logic [NUM_CELLS-1:0] io_prev_q;
  logic oe_prev_q, clk_prev_q;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // ----------------------------------------
  // bus phases and strobes
  // ----------------------------------------
  logic setup_acc, acc, wr_ok, erase_go, preload_go, clk_rise, in_changed, awake;
  logic [PT_BITS-1:0] pt_eff;
  logic [NUM_CELLS-1:0] lvl, out_c, oe_c, fb_c, is_reg, is_in, is_cout;

  assign setup_acc = psel & penable & ~pready_q;
  assign acc = psel & penable & pready_q;
  assign wr_ok = acc & pwrite & ~pslverr_q;
  assign erase_go = wr_ok & (paddr == OFF_CTRL) & pwdata[CTRL_ERASE_BIT] & prog_q;
  assign preload_go = wr_ok & (paddr == OFF_CTRL) & pwdata[CTRL_PRELOAD_BIT];
  assign clk_rise = clk_pin & ~clk_prev_q;
  // clock pin deliberately left out of the wake detector
  assign in_changed = (pterm != pt_prev_q) | (io_in != io_prev_q) | (oe_n_pin != oe_prev_q);
  assign awake = ~standby_q | in_changed;
  assign pt_eff = ZERO_POWER ? (pterm & ptmask_q) : pterm;

  // ----------------------------------------
  // macrocell datapath
  // ----------------------------------------
  always_comb begin
    pldmc_mode_t md;
    logic [PT_PER_CELL-1:0] pt;
    logic sum, ded, adj, edge_ded;
    md = PLDMC_OFF;
    pt = '0;
    sum = 1'b0;
    ded = 1'b0;
    adj = 1'b0;
    edge_ded = 1'b0;
    for (int i = 0; i < NUM_CELLS; i++) begin
      md = pldmc_decode(regs_ok_q, emul_q, mode_q[i]);
      pt = pt_eff[i*PT_PER_CELL +: PT_PER_CELL];
      is_reg[i] = (md == PLDMC_REG);
      is_in[i] = (md == PLDMC_IN);
      is_cout[i] = (md == PLDMC_COUT);
      // eight terms for registered and dedicated output, seven otherwise
      sum = (md == PLDMC_REG || md == PLDMC_COUT) ? |pt : |pt[PT_PER_CELL-2:0];
      lvl[i] = pol_q[i] ? sum : ~sum;
      ded = (i == 0) ? oe_n_pin : clk_pin;
      adj = (i < NUM_CELLS / 2) ? io_in[(i + 1) % NUM_CELLS] : io_in[(i + NUM_CELLS - 1) % NUM_CELLS];
      edge_ded = (i == 0 || i == NUM_CELLS - 1) & regs_ok_q;
      case (md)
        PLDMC_REG: begin
          out_c[i] = ~q_q[i];
          oe_c[i] = ~oe_n_pin;
          fb_c[i] = ~q_q[i];
        end
        PLDMC_RIO: begin
          out_c[i] = lvl[i];
          oe_c[i] = pt[PT_PER_CELL-1];
          fb_c[i] = io_in[i];
        end
        PLDMC_COUT: begin
          out_c[i] = lvl[i];
          oe_c[i] = 1'b1;
          fb_c[i] = (i == 3 || i == 4) ? 1'b0 : (edge_ded ? ded : lvl[i]);
        end
        PLDMC_CIO: begin
          out_c[i] = lvl[i];
          oe_c[i] = pt[PT_PER_CELL-1];
          fb_c[i] = edge_ded ? ded : io_in[i];
        end
        PLDMC_IN: begin
          out_c[i] = 1'b0;
          oe_c[i] = 1'b0;
          fb_c[i] = edge_ded ? ded : adj;
        end
        default: begin
          out_c[i] = 1'b0;
          oe_c[i] = 1'b0;
          fb_c[i] = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers, pins and standby next state
  // ----------------------------------------
  always_comb begin
    q_d = q_q;
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (is_reg[i] && clk_rise && !prog_q) begin
        q_d[i] = ~lvl[i];
      end
    end
    if (preload_go) begin
      q_d = ~io_in;
    end
    io_out_d = io_out_q;
    io_oe_d = io_oe_q;
    fb_d = fb_q;
    if (prog_q) begin
      io_oe_d = '0;
      io_out_d = '0;
      fb_d = '0;
    end else if (awake) begin
      io_out_d = out_c;
      io_oe_d = oe_c;
      fb_d = fb_c;
    end
    // outputs above freeze while asleep
    idle_d = idle_q;
    standby_d = 1'b0;
    if (in_changed || prog_q) begin
      idle_d = '0;
    end else if (idle_q != IDLE_LAST) begin
      idle_d = idle_q + IDLE_W'(1);
    end
    standby_d = ZERO_POWER & ~in_changed & ~prog_q & (standby_q | (idle_q == IDLE_LAST));
  end

  // ----------------------------------------
  // register file next state
  // ----------------------------------------
  always_comb begin
    regs_ok_d = regs_ok_q;
    emul_d = emul_q;
    mode_d = mode_q;
    pol_d = pol_q;
    ptmask_d = ptmask_q;
    sig_d = sig_q;
    prog_d = prog_q;
    secure_d = secure_q;
    pready_d = setup_acc;
    prdata_d = DATA_ZERO;
    pslverr_d = 1'b0;
    // answer is prepared during the first access cycle
    if (setup_acc) begin
      case (paddr)
        OFF_CTRL: begin
          prdata_d[CTRL_PROG_BIT] = prog_q;
          prdata_d[CTRL_SECURE_BIT] = secure_q;
          prdata_d[CTRL_STANDBY_BIT] = standby_q;
        end
        OFF_CONFIG, OFF_PTMASK_LO, OFF_PTMASK_HI: begin
          if (secure_q) begin
            pslverr_d = 1'b1;
          end else if (pwrite) begin
            pslverr_d = ~prog_q;
          end else if (paddr == OFF_CONFIG) begin
            prdata_d[CFG_REGS_OK_BIT] = regs_ok_q;
            prdata_d[CFG_EMUL_BIT] = emul_q;
            prdata_d[CFG_MODE_LSB +: NUM_CELLS] = mode_q;
            prdata_d[CFG_POL_LSB +: NUM_CELLS] = pol_q;
          end else begin
            prdata_d = (paddr == OFF_PTMASK_LO) ? ptmask_q[31:0] : ptmask_q[63:32];
          end
        end
        OFF_SIG_LO, OFF_SIG_HI: begin
          if (pwrite) begin
            pslverr_d = ~prog_q | secure_q;
          end else begin
            prdata_d = (paddr == OFF_SIG_LO) ? sig_q[31:0] : sig_q[63:32];
          end
        end
        OFF_STATUS: prdata_d[NUM_CELLS-1:0] = q_q;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (wr_ok) begin
      case (paddr)
        OFF_CTRL: prog_d = pwdata[CTRL_PROG_BIT];
        OFF_CONFIG: begin
          regs_ok_d = pwdata[CFG_REGS_OK_BIT];
          emul_d = pwdata[CFG_EMUL_BIT];
          mode_d = pwdata[CFG_MODE_LSB +: NUM_CELLS];
          pol_d = pwdata[CFG_POL_LSB +: NUM_CELLS];
        end
        OFF_PTMASK_LO: ptmask_d[31:0] = pwdata;
        OFF_PTMASK_HI: ptmask_d[63:32] = pwdata;
        OFF_SIG_LO: sig_d[31:0] = pwdata;
        OFF_SIG_HI: sig_d[63:32] = pwdata;
        default: ;
      endcase
    end
    if (erase_go) begin
      regs_ok_d = 1'b0;
      emul_d = 1'b0;
      mode_d = CELL_RESET;
      pol_d = CELL_RESET;
      ptmask_d = PTMASK_ERASED;
      sig_d = SIG_ERASED;
      secure_d = 1'b0;
    end
    // a set in the same write as an erase wins
    if (wr_ok && paddr == OFF_CTRL && pwdata[CTRL_SECURE_BIT] && prog_q) begin
      secure_d = 1'b1;
    end
  end

  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regs_ok_q <= 1'b0;
      emul_q <= 1'b0;
      mode_q <= CELL_RESET;
      pol_q <= CELL_RESET;
      ptmask_q <= PTMASK_ERASED;
      sig_q <= SIG_ERASED;
      prog_q <= 1'b0;
      secure_q <= 1'b0;
      q_q <= CELL_RESET;
      io_out_q <= CELL_RESET;
      io_oe_q <= CELL_RESET;
      fb_q <= CELL_RESET;
      standby_q <= 1'b0;
      idle_q <= '0;
      pt_prev_q <= '0;
      io_prev_q <= CELL_RESET;
      oe_prev_q <= 1'b0;
      clk_prev_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= DATA_ZERO;
    end else begin
      regs_ok_q <= regs_ok_d;
      emul_q <= emul_d;
      mode_q <= mode_d;
      pol_q <= pol_d;
      ptmask_q <= ptmask_d;
      sig_q <= sig_d;
      prog_q <= prog_d;
      secure_q <= secure_d;
      q_q <= q_d;
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
      fb_q <= fb_d;
      standby_q <= standby_d;
      idle_q <= idle_d;
      pt_prev_q <= pterm;
      io_prev_q <= io_in;
      oe_prev_q <= oe_n_pin;
      clk_prev_q <= clk_pin;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign fb = fb_q;
  assign standby = standby_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_read_secured;
    acc && !pwrite && paddr == OFF_CONFIG && secure_q;
  endsequence
  sequence s_asleep_quiet;
    standby_q && !in_changed && !prog_q;
  endsequence

  property p_reset_clear;
    disable iff (1'b0) !rst_n |=> (q_q == CELL_RESET && io_oe_q == CELL_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("flops not cleared");
  property p_secure_read;
    s_cfg_read_secured |-> (prdata_q == DATA_ZERO && pslverr_q);
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured readback");
  property p_sig_read;
    acc && !pwrite && paddr == OFF_SIG_HI |-> (prdata_q == sig_q[63:32] && !pslverr_q);
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature unreadable");
  property p_secure_clear;
    $fell(secure_q) |-> $past(erase_go);
  endproperty
  a_secure_clear: assert property (p_secure_clear) else $error("security lost");
  property p_preload;
    preload_go |=> q_q == ~$past(io_in);
  endproperty
  a_preload: assert property (p_preload) else $error("preload failed");
  property p_hold;
    s_asleep_quiet |=> $stable(io_out_q) && $stable(io_oe_q);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved in standby");
  property p_clk_no_wake;
    s_asleep_quiet ##1 !in_changed |-> standby_q;
  endproperty
  a_clk_no_wake: assert property (p_clk_no_wake) else $error("woke without input");
  property p_enter;
    ZERO_POWER && !standby_q && !prog_q && idle_q == IDLE_LAST && !in_changed |=> standby_q;
  endproperty
  a_enter: assert property (p_enter) else $error("no standby entry");
  property p_wake;
    standby_q && in_changed && !prog_q |=> !standby_q && io_out_q == $past(out_c);
  endproperty
  a_wake: assert property (p_wake) else $error("slow wake");
  property p_input_off;
    is_in[2] && !prog_q && awake |=> !io_oe_q[2];
  endproperty
  a_input_off: assert property (p_input_off) else $error("input cell drives");
  property p_capture;
    is_reg[5] && clk_rise && !prog_q && !preload_go |=> q_q[5] == ~$past(lvl[5]);
  endproperty
  a_capture: assert property (p_capture) else $error("register missed edge");
  property p_no_fb;
    is_cout[3] && !prog_q && awake |=> !fb_q[3];
  endproperty
  a_no_fb: assert property (p_no_fb) else $error("cell four feeds back");

endmodule : pldmc_top

// file: tb/pldmc_board.sv
module pldmc_board
  import pldmc_pkg::*;
(
  input wire logic clock,
  input wire logic [NUM_CELLS-1:0] io_out,
  input wire logic [NUM_CELLS-1:0] io_oe,
  output logic [PT_BITS-1:0] pterm,
  output logic clk_pin,
  output logic oe_n_pin,
  output logic [NUM_CELLS-1:0] io_in
);
  logic [NUM_CELLS-1:0] ext_q;

  // pin level: device drive wins where enabled, board drive elsewhere
  assign io_in = (io_oe & io_out) | (~io_oe & ext_q);

  // quiet board at time zero, device clock pin parked low
  initial begin
    pterm = '0;
    clk_pin = 1'b0;
    oe_n_pin = 1'b0;
    ext_q = 8'h00;
  end

  // new array terms, board pin drive and enable pin, launched after an edge
  task automatic set_pins(input logic [PT_BITS-1:0] pt, input logic [7:0] ext, input logic oe_n);
    @(posedge clock);
    pterm <= pt;
    ext_q <= ext;
    oe_n_pin <= oe_n;
  endtask : set_pins

  // one rising edge on the device clock pin, low otherwise
  task automatic pulse_clk();
    @(posedge clock);
    clk_pin <= 1'b1;
    @(posedge clock);
    clk_pin <= 1'b0;
  endtask : pulse_clk
endmodule : pldmc_board

// file: tb/tb_top.sv
module tb_top
  import pldmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr, clk_pin, oe_n_pin, standby;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er;
  logic [PT_BITS-1:0] pterm, pt2;
  logic [NUM_CELLS-1:0] io_in, io_out, io_oe, fb;
  int num_errors = 0;
  int compares = 0;

  // 200 MHz system clock
  always #2.5 clock = ~clock;

  pldmc_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pterm(pterm), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .fb(fb), .standby(standby));

  pldmc_board board_u (.clock(clock), .io_out(io_out), .io_oe(io_oe), .pterm(pterm),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 20) begin
      num_errors++;
      $display("BAD %0t no bus answer", $time);
    end
    rd = prdata;
    er = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk(er, ee, $sformatf("write resp %h", a));
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk({er, rd}, {ee, ed}, $sformatf("read %h", a));
  endtask : rdc

  function automatic logic [63:0] spread(input logic [7:0] cells, input logic [7:0] term);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (cells[i]) begin
        r[8*i +: 8] = term;
      end
    end
    return r;
  endfunction : spread

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // program a configuration, leave programming, then wiggle pins to wake
  task automatic mode_run(input logic [31:0] cfg, input logic [63:0] pt, input logic [7:0] ext,
      input logic oe_n);
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    wr(OFF_CONFIG, cfg, 1'b0);
    wr(OFF_CTRL, 32'h0000_0000, 1'b0);
    board_u.set_pins(~pt, ~ext, ~oe_n);
    board_u.set_pins(pt, ext, oe_n);
    settle();
  endtask : mode_run

  task automatic chk_pins(input logic [7:0] o, input logic [7:0] e, input logic [7:0] f);
    chk({io_out & io_oe, io_oe, fb}, {o, e, f}, "pins");
  endtask : chk_pins

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({io_out, io_oe, fb, standby}, 25'h0, "reset pins");
    rdc(OFF_STATUS, 32'h0000_0000, 1'b0);
    wr(OFF_CONFIG, 32'h0000_0003, 1'b1);
    rdc(OFF_CONFIG, 32'h0000_0000, 1'b0);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(er, 1'b1, "unmapped read");
    // registered cells straight after power-up
    mode_run(32'h00FF_0002, '0, 8'h00, 1'b0);
    chk_pins(8'hFF, 8'hFF, 8'hFF);
    board_u.set_pins('0, 8'h00, 1'b1);
    settle();
    chk(io_oe, 8'h00, "enable pin off");
    board_u.set_pins(spread(8'hA5, 8'h10), 8'h00, 1'b0);
    board_u.pulse_clk();
    settle();
    chk_pins(8'hA5, 8'hFF, 8'hA5);
    rdc(OFF_STATUS, 32'h0000_005A, 1'b0);
    // standby entry, clock-only activity, wake
    board_u.set_pins(spread(8'h3C, 8'h10), 8'h00, 1'b0);
    repeat (14) @(posedge clock);
    #1;
    chk(standby, 1'b1, "standby entry");
    board_u.pulse_clk();
    settle();
    chk({standby, io_out}, {1'b1, 8'hA5}, "held in standby");
    rdc(OFF_STATUS, 32'h0000_00C3, 1'b0);
    board_u.set_pins(spread(8'h3C, 8'h11), 8'h00, 1'b0);
    settle();
    chk({standby, io_out}, {1'b0, 8'h3C}, "wake");
    // signature, security, preload, erase
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    wr(OFF_SIG_LO, 32'h1234_5678, 1'b0);
    wr(OFF_SIG_HI, 32'h9ABC_DEF0, 1'b0);
    wr(OFF_CTRL, 32'h0000_0003, 1'b0);
    rdc(OFF_CONFIG, 32'h0000_0000, 1'b1);
    wr(OFF_PTMASK_LO, 32'h0000_0000, 1'b1);
    wr(OFF_SIG_LO, 32'h0000_0000, 1'b1);
    rdc(OFF_SIG_LO, 32'h1234_5678, 1'b0);
    rdc(OFF_SIG_HI, 32'h9ABC_DEF0, 1'b0);
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd[1:0], 2'b11, "secure kept");
    board_u.set_pins('0, 8'h69, 1'b0);
    wr(OFF_CTRL, 32'h0000_0009, 1'b0);
    rdc(OFF_STATUS, 32'h0000_0096, 1'b0);
    wr(OFF_CTRL, 32'h0000_0005, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd[1:0], 2'b01, "secure erased");
    rdc(OFF_SIG_HI, 32'h0000_0000, 1'b0);
    rdc(OFF_CONFIG, 32'h0000_0000, 1'b0);
    // combinatorial output, both polarities, unused terms
    mode_run(32'h0000_0001, spread(8'h0F, 8'h01), 8'h00, 1'b0);
    chk({io_out, io_oe, fb[4:3]}, {8'hF0, 8'hFF, 2'b00}, "comb low");
    mode_run(32'h00FF_0001, spread(8'h0F, 8'h01), 8'h00, 1'b0);
    chk({io_out, io_oe, fb[4:3]}, {8'h0F, 8'hFF, 2'b00}, "comb high");
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    wr(OFF_PTMASK_LO, 32'hFEFE_FEFE, 1'b0);
    mode_run(32'h00FF_0001, spread(8'h0F, 8'h01), 8'h00, 1'b0);
    chk(io_out, 8'h00, "unused terms");
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    wr(OFF_PTMASK_LO, 32'hFFFF_FFFF, 1'b0);
    // i/o cells: seven-term sum, eighth term enables, pin fed back except edge cells with regs_ok set (enable pin, clock pin)
    pt2 = spread(8'hF0, 8'h80) | spread(8'h3C, 8'h01);
    mode_run(32'h00FF_FF03, pt2, 8'h05, 1'b0);
    chk_pins(8'h30, 8'hF0, 8'h34);
    mode_run(32'h00FF_FF02, pt2, 8'h05, 1'b0);
    chk_pins(8'h30, 8'hF0, 8'h35);
    // dedicated inputs: neighbours, enable pin and clock pin
    mode_run(32'h0000_FF01, '0, 8'h96, 1'b0);
    chk_pins(8'h00, 8'h00, 8'h2A);
    mode_run(32'h0000_FF01, '0, 8'h96, 1'b1);
    chk_pins(8'h00, 8'h00, 8'h2B);
    stop_test();
  end
endmodule : tb_top
